// File: src/mck_logic.sv
// machine check classification, masking, code assembly and hard stop
//
// Functional notes
// [RULE_01] recovery interrupt needs master and recovery mask
// [RULE_02] limit recovery also needs limit mask
// [RULE_03] code bit 2 on recovery; retry logout
// [RULE_04] bit 17 with bit 2 on limit
// [RULE_05] timer damage gated by master and external
// [RULE_06] clock damage sets bit 4, same gating
// [RULE_07] clock invalid sticks for read-time condition
// [RULE_08] processing damage bit 1, master only
// [RULE_09] failing address stored at 248-251
// [RULE_10] logout bit marks control versus processor storage
// [RULE_11] key failure sets bit 18
// [RULE_12] backup bit 14 when state intact
// [RULE_13] system damage bit 0, master only
// [RULE_14] hard stop halts, no logout written
// [RULE_15] nested hard error causes hard stop
// [RULE_16] reset clears recovery and limit masks
// [RULE_17] reset sets external mask
// [RULE_18] reset clears master; load sets it
// [RULE_19] reset leaves hard stop enabled
// [RULE_20] master clear masks every type
// [RULE_21] taken interrupt presents disabled pending types too
// [RULE_22] one pending condition per type
// [RULE_23] interrupt stores code at 232-239
`timescale 1ns/1ps
module mck_logic
  import mck_pkg::*;
(
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // status word and control register 14 (from the core)
  input  wire logic                 psw_load,
  input  wire logic                 psw_master_in,
  input  wire logic                 cr14_write,
  input  wire logic                 cr14_hard_stop_in,
  input  wire logic                 cr14_recovery_in,
  input  wire logic                 cr14_external_in,
  input  wire logic                 cr14_efl_in,
  // error detector pulses
  input  wire logic                 ev_retry_ok,
  input  wire logic                 ev_efl_reached,
  input  wire logic                 ev_timer_damage,
  input  wire logic                 ev_clock_damage,
  input  wire logic                 ev_storage_multibit,
  input  wire logic                 ev_key_failure,
  input  wire logic                 ev_cpu_unretryable,
  input  wire logic                 ev_backup_ok,
  input  wire logic                 ev_system_damage,
  input  wire logic                 ev_control_storage,
  input  wire logic [23:0]          ev_fail_addr,
  // interrupt handshake with the core
  input  wire logic                 int_ack,
  input  wire logic                 hard_done,
  // status and results
  output logic                      psw_master,
  output logic                      recovery_mask,
  output logic                      external_mask,
  output logic                      error_frequency_limit_mask,
  output logic                      hard_stop_en,
  output logic                      mck_int_req,
  output logic                      logout_we,
  output logic [MC_CODE_W-1:0]      mc_code,
  output logic [23:0]               fail_addr,
  output logic                      fail_addr_valid,
  output logic                      logout_ctl_storage,
  output logic                      logout_retry,
  output logic                      clock_invalid,
  output logic                      hard_stopped
);
  // ----------------------------------------------------------------
  // control state
  // ----------------------------------------------------------------
  logic [MC_NTYPES-1:0] pend_q;
  logic [MC_NTYPES-1:0] enab;
  logic                 limit_pend_q;
  logic                 retry_pend_q;
  logic                 key_pend_q;
  logic                 backup_pend_q;
  logic                 ctl_pend_q;
  logic [23:0]          addr_pend_q;
  logic                 addr_pend_v_q;
  logic                 in_hard_q;
  logic                 hard_ev;
  logic                 take;
  logic                 retry_req;
  logic                 limit_req;
  logic [MC_CODE_W-1:0] code_d;

  assign hard_ev = ev_storage_multibit | ev_key_failure | ev_cpu_unretryable | ev_system_damage;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hard_stop_en               <= MC_RST_HARD_STOP_EN;  // [RULE_19]
      recovery_mask              <= MC_RST_RECOVERY_MASK; // [RULE_16]
      error_frequency_limit_mask <= MC_RST_EFL_MASK;      // [RULE_16]
      external_mask              <= MC_RST_EXTERNAL_MASK; // [RULE_17]
    end else if (cr14_write) begin
      hard_stop_en               <= cr14_hard_stop_in;    // [RULE_14]
      recovery_mask              <= cr14_recovery_in;
      external_mask              <= cr14_external_in;
      error_frequency_limit_mask <= cr14_efl_in;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      psw_master <= MC_RST_MASTER;  // [RULE_18]
    end else if (psw_load) begin
      psw_master <= psw_master_in;  // [RULE_18]
    end
  end

  // ----------------------------------------------------------------
  // pending conditions, one per type; repeats merge
  // ----------------------------------------------------------------
  // limit only counts as a recovery request when its own mask allows it
  assign limit_req = ev_efl_reached & error_frequency_limit_mask; // [RULE_02]
  assign retry_req = ev_retry_ok;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pend_q        <= '0;
      limit_pend_q  <= 1'b0;
      retry_pend_q  <= 1'b0;
      key_pend_q    <= 1'b0;
      backup_pend_q <= 1'b0;
      ctl_pend_q    <= 1'b0;
      addr_pend_q   <= '0;
      addr_pend_v_q <= 1'b0;
    end else if (!hard_stopped) begin
      // set wins over the clear caused by presentation
      pend_q[MCK_SYSTEM_RECOVERY] <= (pend_q[MCK_SYSTEM_RECOVERY] & ~take) | retry_req | limit_req; // [RULE_22]
      pend_q[MCK_TIMER_DAMAGE]    <= (pend_q[MCK_TIMER_DAMAGE] & ~take) | ev_timer_damage;
      pend_q[MCK_CLOCK_DAMAGE]    <= (pend_q[MCK_CLOCK_DAMAGE] & ~take) | ev_clock_damage;
      pend_q[MCK_PROC_DAMAGE]     <= (pend_q[MCK_PROC_DAMAGE] & ~take)
                                     | ev_storage_multibit | ev_key_failure | ev_cpu_unretryable; // [RULE_08]
      pend_q[MCK_SYSTEM_DAMAGE]   <= (pend_q[MCK_SYSTEM_DAMAGE] & ~take) | ev_system_damage; // [RULE_13]
      limit_pend_q  <= (limit_pend_q & ~take) | limit_req;
      retry_pend_q  <= (retry_pend_q & ~take) | retry_req;
      key_pend_q    <= (key_pend_q & ~take) | ev_key_failure;
      // backup only when the unretryable failure left state intact
      backup_pend_q <= (backup_pend_q & ~take) | (ev_cpu_unretryable & ev_backup_ok); // [RULE_12]
      if (ev_storage_multibit | ev_key_failure) begin
        addr_pend_q   <= ev_fail_addr; // [RULE_09]
        addr_pend_v_q <= 1'b1;
        ctl_pend_q    <= ev_storage_multibit & ev_control_storage; // [RULE_10]
      end else if (take) begin
        addr_pend_v_q <= 1'b0;
        ctl_pend_q    <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // masking
  // ----------------------------------------------------------------
  always_comb begin
    enab                      = '0;
    enab[MCK_SYSTEM_RECOVERY] = recovery_mask;  // [RULE_01]
    enab[MCK_TIMER_DAMAGE]    = external_mask;  // [RULE_05]
    enab[MCK_CLOCK_DAMAGE]    = external_mask;  // [RULE_06]
    enab[MCK_PROC_DAMAGE]     = 1'b1;
    enab[MCK_SYSTEM_DAMAGE]   = 1'b1;
    enab                      = enab & {MC_NTYPES{psw_master}}; // [RULE_20]
  end

  // one interrupt carries every pending type, enabled or not
  assign take = mck_int_req & int_ack & ~hard_stopped; // [RULE_21]

  always_comb begin
    code_d                               = '0;
    code_d[MC_SYSTEM_DAMAGE_BIT]         = pend_q[MCK_SYSTEM_DAMAGE];   // [RULE_13]
    code_d[MC_PROC_DAMAGE_BIT]           = pend_q[MCK_PROC_DAMAGE];     // [RULE_08]
    code_d[MC_RECOVERY_BIT]              = pend_q[MCK_SYSTEM_RECOVERY]; // [RULE_03]
    code_d[MC_CLOCK_DAMAGE_BIT]          = pend_q[MCK_CLOCK_DAMAGE];    // [RULE_06]
    code_d[MC_TIMER_DAMAGE_BIT]          = pend_q[MCK_TIMER_DAMAGE];
    code_d[MC_BACKUP_BIT]                = backup_pend_q;               // [RULE_12]
    code_d[MC_STOR_LIMIT_BIT]            = limit_pend_q;                // [RULE_04]
    code_d[MC_KEY_ERROR_BIT]             = key_pend_q;                  // [RULE_11]
  end

  // ----------------------------------------------------------------
  // interrupt request and logout
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mck_int_req <= 1'b0;
    end else begin
      // drop for one cycle after a take so the core sees fresh data
      mck_int_req <= |(pend_q & enab) & ~take & ~hard_stopped; // [RULE_20]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      logout_we          <= 1'b0;
      mc_code            <= '0;
      fail_addr          <= '0;
      fail_addr_valid    <= 1'b0;
      logout_ctl_storage <= 1'b0;
      logout_retry       <= 1'b0;
    end else begin
      logout_we <= take; // [RULE_23]
      if (take) begin
        mc_code            <= code_d;             // [RULE_23]
        fail_addr          <= addr_pend_q;        // [RULE_09]
        fail_addr_valid    <= addr_pend_v_q;
        logout_ctl_storage <= ctl_pend_q;         // [RULE_10]
        // recovery bit alone means a clean retry: processor logout is produced
        logout_retry       <= retry_pend_q & ~limit_pend_q; // [RULE_03]
      end
    end
  end

  // ----------------------------------------------------------------
  // clock validity and hard stop
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clock_invalid <= 1'b0;
    end else if (ev_clock_damage) begin
      clock_invalid <= 1'b1; // [RULE_07]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      in_hard_q <= 1'b0;
    end else if (take && (pend_q[MCK_PROC_DAMAGE] || pend_q[MCK_SYSTEM_DAMAGE])) begin
      in_hard_q <= 1'b1;
    end else if (hard_done) begin
      in_hard_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hard_stopped <= 1'b0;
    end else if (hard_stop_en && in_hard_q && hard_ev) begin
      hard_stopped <= 1'b1; // [RULE_15] [RULE_14]
    end
  end
endmodule

// File: src/mck_pkg.sv
// package for the machine check classification block
package mck_pkg;
  // machine check code bit positions (64-bit code, vector index n carries code bit n)
  localparam int MC_SYSTEM_DAMAGE_BIT  = 0;
  localparam int MC_PROC_DAMAGE_BIT    = 1;
  localparam int MC_RECOVERY_BIT       = 2;
  localparam int MC_CLOCK_DAMAGE_BIT   = 4;
  localparam int MC_TIMER_DAMAGE_BIT   = 5;
  localparam int MC_BACKUP_BIT         = 14;
  localparam int MC_STOR_LIMIT_BIT     = 17;
  localparam int MC_KEY_ERROR_BIT      = 18;
  localparam int MC_CODE_W             = 64;
  // fixed area byte addresses
  localparam logic [11:0] MC_CODE_ADDR      = 12'h0e8; // 232
  localparam logic [11:0] MC_FAIL_ADDR_ADDR = 12'h0f8; // 248
  localparam logic [11:0] MC_LOGOUT_ADDR    = 12'h100; // 256
  // control register 14 and status word master reset values
  localparam logic MC_RST_HARD_STOP_EN  = 1'b1;
  localparam logic MC_RST_RECOVERY_MASK = 1'b0;
  localparam logic MC_RST_EXTERNAL_MASK = 1'b1;
  localparam logic MC_RST_EFL_MASK      = 1'b0;
  localparam logic MC_RST_MASTER        = 1'b0;
  // machine check types
  typedef enum logic [2:0] {
    MCK_SYSTEM_RECOVERY, MCK_TIMER_DAMAGE, MCK_CLOCK_DAMAGE, MCK_PROC_DAMAGE, MCK_SYSTEM_DAMAGE
  } mck_type_t;
  localparam int MC_NTYPES = 5;
endpackage

// File: tb/mck_logic_props.sv
// assertion checker for the machine check block ports
`timescale 1ns/1ps
module mck_logic_props
  import mck_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // core and error detector side inputs
  input wire logic int_ack,
  input wire logic ev_clock_damage,
  // status and results
  input wire logic psw_master,
  input wire logic recovery_mask,
  input wire logic external_mask,
  input wire logic error_frequency_limit_mask,
  input wire logic hard_stop_en,
  input wire logic mck_int_req,
  input wire logic logout_we,
  input wire logic [mck_pkg::MC_CODE_W-1:0] mc_code,
  input wire logic fail_addr_valid,
  input wire logic logout_retry,
  input wire logic clock_invalid,
  input wire logic hard_stopped
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // --------------------------------
  // properties
  // --------------------------------
  sequence s_take; mck_int_req && int_ack && !hard_stopped; endsequence
  property p_take; s_take |=> logout_we && !mck_int_req; endproperty
  a_take: assert property (p_take) else $error("take without logout");
  property p_we; logout_we |=> !logout_we; endproperty
  a_we: assert property (p_we) else $error("logout strobe too long");
  property p_master; !psw_master [*2] |-> !mck_int_req; endproperty
  a_master: assert property (p_master) else $error("request while master clear");
  property p_limit; logout_we && mc_code[MC_STOR_LIMIT_BIT] |-> mc_code[MC_RECOVERY_BIT]; endproperty
  a_limit: assert property (p_limit) else $error("limit flag alone");
  property p_retry; logout_we |-> logout_retry == (mc_code[MC_RECOVERY_BIT] && !mc_code[MC_STOR_LIMIT_BIT]); endproperty
  a_retry: assert property (p_retry) else $error("retry logout wrong");
  property p_key; logout_we && mc_code[MC_KEY_ERROR_BIT] |-> mc_code[MC_PROC_DAMAGE_BIT] && fail_addr_valid; endproperty
  a_key: assert property (p_key) else $error("key error fields wrong");
  property p_clk; (ev_clock_damage && !hard_stopped) || clock_invalid |=> clock_invalid; endproperty
  a_clk: assert property (p_clk) else $error("clock invalid lost");
  property p_stop; hard_stopped |=> hard_stopped && !logout_we; endproperty
  a_stop: assert property (p_stop) else $error("activity after hard stop");
  property p_stop_en; $rose(hard_stopped) |-> $past(hard_stop_en); endproperty
  a_stop_en: assert property (p_stop_en) else $error("hard stop while disabled");
  property p_rst; disable iff (1'b0) rst |=> !psw_master && !recovery_mask && external_mask
    && !error_frequency_limit_mask && hard_stop_en; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule

// File: tb/mck_err_src.sv
// error detector model giving one-cycle event pulses
`timescale 1ns/1ps
module mck_err_src (
  // clock
  input wire logic        sys_clk,
  // requests from the bench
  input wire logic [9:0]  fire,
  input wire logic [23:0] addr_in,
  // detector outputs
  output logic [9:0]      ev,
  output logic [23:0]     addr
);
  always_ff @(posedge sys_clk) begin
    ev <= fire;
    // address only valid with a storage event; scrambled otherwise so stale values are never trusted
    addr <= (fire[4] | fire[5]) ? addr_in : ~addr;
  end
endmodule

// File: tb/mck_logic_test.sv
// self-checking bench for the machine check block
`timescale 1ns/1ps
module mck_logic_test;
  import mck_pkg::*;
  typedef struct {logic [9:0] ev; logic [64:0] exp;} mck_row_t;
  logic        sys_clk = 1'b0;
  logic        rst, psw_load, psw_master_in, cr14_write, int_ack, hard_done;
  logic        cr14_hard_stop_in, cr14_recovery_in, cr14_external_in, cr14_efl_in;
  logic        psw_master, recovery_mask, external_mask, error_frequency_limit_mask, hard_stop_en;
  logic        mck_int_req, logout_we, fail_addr_valid, logout_ctl_storage, logout_retry;
  logic        clock_invalid, hard_stopped;
  logic [63:0] mc_code;
  logic [23:0] fail_addr, ev_fail_addr;
  logic [9:0]  fire, ev;
  mck_row_t    rows [8];
  int          error_cnt = 0;
  int          n_compared = 0;
  always #2.5 sys_clk = ~sys_clk;
  mck_err_src u_src (.sys_clk, .fire, .addr_in(24'h3a5c10), .ev, .addr(ev_fail_addr));
  mck_logic dut (.sys_clk, .rst, .psw_load, .psw_master_in, .cr14_write, .cr14_hard_stop_in,
    .cr14_recovery_in, .cr14_external_in, .cr14_efl_in, .ev_retry_ok(ev[0]), .ev_efl_reached(ev[1]),
    .ev_timer_damage(ev[2]), .ev_clock_damage(ev[3]), .ev_storage_multibit(ev[4]), .ev_key_failure(ev[5]),
    .ev_cpu_unretryable(ev[6]), .ev_backup_ok(ev[7]), .ev_system_damage(ev[8]), .ev_control_storage(ev[9]),
    .ev_fail_addr, .int_ack, .hard_done, .psw_master, .recovery_mask, .external_mask,
    .error_frequency_limit_mask, .hard_stop_en, .mck_int_req, .logout_we, .mc_code, .fail_addr,
    .fail_addr_valid, .logout_ctl_storage, .logout_retry, .clock_invalid, .hard_stopped);
  // --------------------------------
  // helpers
  // --------------------------------
  function automatic logic [64:0] b(input int n);
    return 65'h1 << n;
  endfunction
  task automatic chk(input logic [64:0] got, input logic [64:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic cfg(input logic m, input logic [3:0] c);
    tick;
    {psw_load, cr14_write, psw_master_in} = {2'b11, m};
    {cr14_hard_stop_in, cr14_recovery_in, cr14_external_in, cr14_efl_in} = c;
    tick;
    {psw_load, cr14_write} = 2'b00;
  endtask
  task automatic fire_ev(input logic [9:0] v);
    tick;
    fire = v;
    tick;
    fire = '0;
  endtask
  // six cycles is well past the two-cycle request latency
  task automatic quiet;
    logic s;
    s = 1'b0;
    repeat (6) begin
      tick;
      s = s | logout_we | (mck_int_req & !int_ack);
    end
    chk(65'(s), 65'h0);
  endtask
  task automatic take(input logic [64:0] exp, input logic hd);
    int k;
    k = 0;
    while (mck_int_req !== 1'b1 && k < 10) begin
      tick;
      k++;
    end
    int_ack = 1'b1;
    tick;
    int_ack = 1'b0;
    chk(65'(logout_we), 65'h1);
    chk({logout_ctl_storage, mc_code}, exp);
    hard_done = hd;
    tick;
    hard_done = 1'b0;
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #20000;
    error_cnt++;
    end_sim;
  end
  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    {rst, psw_load, psw_master_in, cr14_write, int_ack, hard_done, fire} = {6'b100000, 10'h0};
    {cr14_hard_stop_in, cr14_recovery_in, cr14_external_in, cr14_efl_in} = 4'h0;
    repeat (12) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    chk(65'({psw_master, recovery_mask, external_mask, error_frequency_limit_mask, hard_stop_en}), 65'h05);
    $display("reset test done");
    rows = '{'{10'h001, b(2)}, '{10'h002, b(2) | b(17)}, '{10'h004, b(MC_TIMER_DAMAGE_BIT)}, '{10'h008, b(4)},
             '{10'h210, b(64) | b(1)}, '{10'h020, b(1) | b(18)}, '{10'h0c0, b(1) | b(14)}, '{10'h100, b(0)}};
    cfg(1'b1, 4'hf);
    foreach (rows[i]) begin
      fire_ev(rows[i].ev);
      take(rows[i].exp, 1'b1);
    end
    chk(65'(clock_invalid), 65'h1);
    $display("table test done");
    cfg(1'b0, 4'hf);
    fire_ev(10'h004);
    fire_ev(10'h004);
    quiet;
    cfg(1'b1, 4'hf);
    take(b(MC_TIMER_DAMAGE_BIT), 1'b1);
    quiet;
    cfg(1'b1, 4'hb);
    fire_ev(10'h001);
    quiet;
    fire_ev(10'h004);
    take(b(2) | b(MC_TIMER_DAMAGE_BIT), 1'b1);
    cfg(1'b1, 4'he);
    fire_ev(10'h002);
    cfg(1'b1, 4'hf);
    quiet;
    $display("mask test done");
    fire_ev(10'h020);
    take(b(1) | b(18), 1'b0);
    chk(65'(fail_addr), 65'h3a5c10);
    fire_ev(10'h100);
    int_ack = 1'b1;
    quiet;
    chk(65'(hard_stopped), 65'h1);
    $display("hard stop test done");
    end_sim;
  end
endmodule
bind mck_logic mck_logic_props u_props (.sys_clk, .rst, .int_ack, .ev_clock_damage, .psw_master,
  .recovery_mask, .external_mask, .error_frequency_limit_mask, .hard_stop_en, .mck_int_req, .logout_we,
  .mc_code, .fail_addr_valid, .logout_retry, .clock_invalid, .hard_stopped);
